// ==== design/swc_pkg.sv ====
// Constants, register map and types for the standby and wake-up sequencer
package swc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ADDR_STANDBY_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STOP_GATE    = 8'h01;
    localparam logic [7:0] ADDR_GATE_BASE    = 8'h02;
    localparam logic [7:0] ADDR_GATE_LAST    = 8'h06;
    localparam logic [7:0] ADDR_STATUS       = 8'h07;
    localparam logic [7:0] RD_UNMAPPED       = 8'h00;

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int HALT_BIT      = 0;
    localparam int STOP_BIT      = 1;
    localparam int FAST_CTL_BIT  = 2;
    localparam logic [3:0] CODE_FIRST  = 4'h5;
    localparam logic [3:0] CODE_SECOND = 4'ha;
    localparam int GATE_COUNT    = 5;
    localparam int GATE_BITS     = GATE_COUNT * 8;
    localparam int OSC_DET_BIT   = 4 * 8 + 4;
    localparam logic [39:0] GATE_RESET = 40'h00_0000_0000;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int SETTLE_PULSES = 8192;
    localparam int CNT_W         = 14;
    localparam logic [1:0] RESUME_SLACK = 2'h2;

    // ****************************************************************
    // Synchroniser lanes
    // ****************************************************************
    localparam int SY_NMI   = 0;
    localparam int SY_PIN0  = 1;
    localparam int SY_STICK = 5;
    localparam int SY_FTICK = 6;
    localparam int SY_SRDY  = 7;
    localparam int SY_FRDY  = 8;
    localparam int SY_W     = 9;

    typedef enum logic [2:0] {
        ST_RUN    = 3'b000,
        ST_HALT   = 3'b001,
        ST_PEND   = 3'b010,
        ST_STOP   = 3'b011,
        ST_WAKE   = 3'b100,
        ST_RESUME = 3'b101
    } swc_state_t;

endpackage

// ==== design/swc_standby_wakeup_control.sv ====
// Standby, stop and wake sequencer with peripheral block gates
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
module swc_standby_wakeup_control
    import swc_pkg::*;
#(
    parameter int SETTLE_COUNT = SETTLE_PULSES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [7:0]  regRdData,
    input  wire logic        nmiPin,
    input  wire logic [3:0]  wakePinReq,
    input  wire logic [3:0]  wakePinEn,
    input  wire logic        maskReq,
    input  wire logic        maskEn,
    input  wire logic        masterIntEnable,
    input  wire logic [1:0]  interruptLevel,
    input  wire logic        cpuOnFastClock,
    input  wire logic        slowOscTick,
    input  wire logic        fastOscTick,
    input  wire logic        slowOscReady,
    input  wire logic        fastOscReady,
    output logic             slowOscEnable,
    output logic             fastOscEnable,
    output logic             periphSlowClkEn,
    output logic             periphFastClkEn,
    output logic             cpuRun,
    output logic             haltActive,
    output logic             stopActive,
    output logic             vectorReq,
    output logic [39:0]      periphHold
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        swc_state_t         state;
        logic [SY_W-1:0]    sync1;
        logic [SY_W-1:0]    sync2;
        logic               sTickD;
        logic               fTickD;
        logic               haltBit;
        logic               stopBit;
        logic               fastCtl;
        logic               codeStage;
        logic               armed;
        logic               fastWas;
        logic               cpuFastLat;
        logic               vecLat;
        logic [1:0]         resumeCnt;
        logic [CNT_W-1:0]   slowCnt;
        logic [CNT_W-1:0]   fastCnt;
        logic               slowDone;
        logic               fastDone;
        logic [39:0]        gates;
        logic [7:0]         rdData;
        logic               vecPulse;
        logic               slowOn;
        logic               fastOn;
    } swc_regs_t;

    swc_regs_t r_ff;
    swc_regs_t nxt_r;

    localparam logic [CNT_W-1:0] SETTLE_LAST =
        CNT_W'(SETTLE_COUNT - 1);

    logic       nmiS;
    logic       pinWake;
    logic       stopWake;
    logic       haltWake;
    logic       vecDecide;
    logic       sTickEdge;
    logic       fTickEdge;
    logic       wrCtrl;
    logic       wrGate;
    logic [2:0] gateIdx;

    // ****************************************************************
    // Wake and vector decisions
    // ****************************************************************
    always_comb begin
        nmiS     = r_ff.sync2[SY_NMI];
        pinWake  = |(r_ff.sync2[SY_PIN0 +: 4] & wakePinEn);
        stopWake = nmiS | pinWake;
        haltWake = nmiS | maskReq;
        // Level 3 is emulator-only; it never vectors
        if (nmiS) begin
            vecDecide = (interruptLevel != 2'h3);
        end else begin
            // A pin wake already carries its own enable flag
            vecDecide = (maskEn | (r_ff.state == ST_STOP)) &
                        masterIntEnable &
                        (interruptLevel < 2'h2);
        end
        sTickEdge = r_ff.sync2[SY_STICK] & ~r_ff.sTickD;
        fTickEdge = r_ff.sync2[SY_FTICK] & ~r_ff.fTickD;
        wrCtrl    = regWr & (regAddr == ADDR_STANDBY_CTRL);
        wrGate    = regWr & (regAddr >= ADDR_GATE_BASE) &
                    (regAddr <= ADDR_GATE_LAST);
        gateIdx   = 3'(regAddr - ADDR_GATE_BASE);
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        nxt_r          = r_ff;
        nxt_r.sync1    = {fastOscReady, slowOscReady, fastOscTick,
                          slowOscTick, wakePinReq, nmiPin};
        nxt_r.sync2    = r_ff.sync1;
        nxt_r.sTickD   = r_ff.sync2[SY_STICK];
        nxt_r.fTickD   = r_ff.sync2[SY_FTICK];
        nxt_r.vecPulse = 1'b0;

        // Register reads
        if (regRd) begin
            if (regAddr == ADDR_STANDBY_CTRL) begin
                nxt_r.rdData = {5'h00, r_ff.fastCtl, r_ff.stopBit,
                                r_ff.haltBit};
            end else if (regAddr == ADDR_STOP_GATE) begin
                nxt_r.rdData = {7'h00, r_ff.armed};
            end else if ((regAddr >= ADDR_GATE_BASE) &&
                         (regAddr <= ADDR_GATE_LAST)) begin
                nxt_r.rdData = r_ff.gates[gateIdx*8 +: 8];
            end else if (regAddr == ADDR_STATUS) begin
                nxt_r.rdData = {2'h0, r_ff.fastDone, r_ff.slowDone,
                                r_ff.vecLat, r_ff.state};
            end else begin
                nxt_r.rdData = RD_UNMAPPED;
            end
        end

        // Stop code gate arming
        if (regWr && (regAddr == ADDR_STOP_GATE)) begin
            if (regWrData[7:4] == CODE_FIRST) begin
                nxt_r.codeStage = 1'b1;
            end else if ((regWrData[7:4] == CODE_SECOND) &&
                         r_ff.codeStage) begin
                nxt_r.armed     = 1'b1;
                nxt_r.codeStage = 1'b0;
            end else begin
                nxt_r.codeStage = 1'b0;
            end
        end

        if (wrGate) begin
            nxt_r.gates[gateIdx*8 +: 8] = regWrData;
        end

        // Settle counters clear while the oscillator is disabled and count ticks while ready
        if (!r_ff.slowOn) begin
            nxt_r.slowCnt  = '0;
            nxt_r.slowDone = 1'b0;
        end else if (r_ff.sync2[SY_SRDY] && !r_ff.slowDone &&
                     sTickEdge) begin
            nxt_r.slowCnt  = r_ff.slowCnt + 1'b1;
            nxt_r.slowDone = (r_ff.slowCnt == SETTLE_LAST);
        end
        if (!r_ff.fastOn) begin
            nxt_r.fastCnt  = '0;
            nxt_r.fastDone = 1'b0;
        end else if (r_ff.sync2[SY_FRDY] && !r_ff.fastDone &&
                     fTickEdge) begin
            nxt_r.fastCnt  = r_ff.fastCnt + 1'b1;
            nxt_r.fastDone = (r_ff.fastCnt == SETTLE_LAST);
        end

        case (r_ff.state)
            ST_RUN: begin
                nxt_r.fastOn = r_ff.fastCtl;
                if (wrCtrl) begin
                    nxt_r.fastCtl = regWrData[FAST_CTL_BIT];
                    if (regWrData[STOP_BIT] && r_ff.armed) begin
                        nxt_r.stopBit = 1'b1;
                        nxt_r.state   = ST_PEND;
                    end else if (regWrData[HALT_BIT]) begin
                        nxt_r.haltBit = 1'b1;
                        nxt_r.state   = ST_HALT;
                    end
                end
            end
            ST_HALT: begin
                if (haltWake) begin
                    nxt_r.haltBit = 1'b0;
                    nxt_r.vecLat  = vecDecide;
                    nxt_r.state   = ST_RESUME;
                    nxt_r.resumeCnt = '0;
                end
            end
            ST_PEND: begin
                nxt_r.state      = ST_STOP;
                nxt_r.armed      = 1'b0;
                nxt_r.codeStage  = 1'b0;
                nxt_r.fastWas    = r_ff.fastOn;
                nxt_r.cpuFastLat = cpuOnFastClock;
                nxt_r.slowOn     = 1'b0;
                nxt_r.fastOn     = 1'b0;
            end
            ST_STOP: begin
                if (stopWake) begin
                    nxt_r.stopBit = 1'b0;
                    nxt_r.vecLat  = vecDecide;
                    nxt_r.slowOn  = 1'b1;
                    nxt_r.fastOn  = r_ff.cpuFastLat |
                                    r_ff.fastWas;
                    nxt_r.state   = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (r_ff.cpuFastLat ? r_ff.fastDone
                                    : r_ff.slowDone) begin
                    nxt_r.state     = ST_RESUME;
                    nxt_r.resumeCnt = '0;
                end
            end
            ST_RESUME: begin
                // Room for the two instructions after the standby write
                if (!r_ff.vecLat) begin
                    nxt_r.state = ST_RUN;
                end else if (r_ff.resumeCnt == RESUME_SLACK - 2'h1) begin
                    nxt_r.vecPulse = 1'b1;
                    nxt_r.vecLat   = 1'b0;
                    nxt_r.state    = ST_RUN;
                end else begin
                    nxt_r.resumeCnt = r_ff.resumeCnt + 2'h1;
                end
            end
            default: begin
                nxt_r.state = ST_RUN;
            end
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            r_ff            <= '0;
            r_ff.state      <= ST_RUN;
            r_ff.gates      <= GATE_RESET;
            r_ff.fastCtl    <= 1'b1;
            r_ff.slowOn     <= 1'b1;
            r_ff.fastOn     <= 1'b1;
            r_ff.slowDone   <= 1'b1;
            r_ff.fastDone   <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    logic released;

    always_comb begin
        released        = (r_ff.state == ST_RUN) ||
                          (r_ff.state == ST_HALT) ||
                          (r_ff.state == ST_RESUME);
        regRdData       = r_ff.rdData;
        slowOscEnable   = r_ff.slowOn;
        fastOscEnable   = r_ff.fastOn;
        periphSlowClkEn = released & r_ff.slowDone;
        periphFastClkEn = released & r_ff.fastDone;
        cpuRun          = (r_ff.state == ST_RUN) ||
                          (r_ff.state == ST_RESUME) ||
                          (r_ff.state == ST_PEND);
        haltActive      = (r_ff.state == ST_HALT);
        stopActive      = (r_ff.state == ST_STOP) ||
                          (r_ff.state == ST_WAKE);
        vectorReq       = r_ff.vecPulse;
    end

    // Gate bits hold reset, stop clocks and block access per unit; the oscillator detector bit acts only while halted
    generate
        for (genvar gi = 0; gi < GATE_BITS; gi++) begin : g_gate
            if (gi == OSC_DET_BIT) begin : g_det
                assign periphHold[gi] =
                    r_ff.gates[gi] & haltActive;
            end else begin : g_norm
                assign periphHold[gi] = r_ff.gates[gi];
            end
        end
    endgenerate

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_stop_two_cycles;
        @(posedge sys_clk) disable iff (!rst_n)
        (wrCtrl && regWrData[STOP_BIT] && r_ff.armed &&
         r_ff.state == ST_RUN) |-> ##2 (r_ff.state == ST_STOP);
    endproperty
    a_stop_two_cycles: assert property (p_stop_two_cycles)
        else $error("stop not entered two cycles after write");

    property p_osc_off_in_stop;
        @(posedge sys_clk) disable iff (!rst_n)
        (r_ff.state == ST_STOP) |-> (!slowOscEnable && !fastOscEnable);
    endproperty
    a_osc_off_in_stop: assert property (p_osc_off_in_stop)
        else $error("oscillator running during stop");

    property p_disarm;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(r_ff.state == ST_STOP) |-> !r_ff.armed;
    endproperty
    a_disarm: assert property (p_disarm)
        else $error("stop gate still armed in stop");

    property p_stop_wake;
        @(posedge sys_clk) disable iff (!rst_n)
        (r_ff.state == ST_STOP && stopWake) |=>
            (!r_ff.stopBit && slowOscEnable);
    endproperty
    a_stop_wake: assert property (p_stop_wake)
        else $error("wake did not clear stop or start slow osc");

    property p_fast_stays_off;
        @(posedge sys_clk) disable iff (!rst_n)
        (r_ff.state == ST_STOP && stopWake && !r_ff.cpuFastLat &&
         !r_ff.fastWas) |=> !fastOscEnable;
    endproperty
    a_fast_stays_off: assert property (p_fast_stays_off)
        else $error("fast osc restarted though it was off");

    property p_halt_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (haltActive && !nmiS && !maskReq) |=> haltActive;
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("halt left without request");

    property p_vector_late;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(vectorReq) |-> ($past(cpuRun, 1) && $past(cpuRun, 2));
    endproperty
    a_vector_late: assert property (p_vector_late)
        else $error("vector without two run cycles");

    property p_slow_release;
        @(posedge sys_clk) disable iff (!rst_n)
        (r_ff.state == ST_WAKE && !r_ff.cpuFastLat) ##1
        (r_ff.state == ST_RESUME) |-> $past(r_ff.slowDone);
    endproperty
    a_slow_release: assert property (p_slow_release)
        else $error("slow cpu released before settle");

    property p_det_gate;
        @(posedge sys_clk) disable iff (!rst_n)
        periphHold[OSC_DET_BIT] == (r_ff.gates[OSC_DET_BIT] &&
                                    r_ff.state == ST_HALT);
    endproperty
    a_det_gate: assert property (p_det_gate)
        else $error("detector gate outside halt");

endmodule

// ==== tb/swc_osc_model.sv ====
// One oscillator: start-up delay, then a free pulse train while enabled
module swc_osc_model #(
    parameter int START = 20,
    parameter int DIV   = 2
) (
    input  wire logic sys_clk,
    input  wire logic oscEnable,
    output logic      oscTick,
    output logic      oscReady
);
    timeunit 1ns;
    timeprecision 1ps;

    int age = 0;
    int div = 0;

    initial begin
        oscTick  = 1'b0;
        oscReady = 1'b0;
    end

    // ********************
    // Start-up and pulses
    // ********************
    always @(posedge sys_clk) begin
        if (oscEnable !== 1'b1) begin
            // Halted oscillator stands still, pulses stop
            age = 0;
            div = 0;
            oscReady <= 1'b0;
            oscTick  <= 1'b0;
        end else if (age < START) begin
            // Start time elapses before any pulse
            age++;
        end else begin
            oscReady <= 1'b1;
            if (div == DIV - 1) begin
                div = 0;
                oscTick <= !oscTick;
            end else begin
                div++;
            end
        end
    end
endmodule

// ==== tb/swc_standby_wakeup_control_tb.sv ====
// Self-checking bench for the standby and wake-up sequencer
module swc_standby_wakeup_control_tb
    import swc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SETTLE = 8;
    typedef struct packed {
        logic nmi; logic mreq; logic men; logic master_int_enable; logic [1:0] lvl; logic vec;
    } swc_row_t;
    localparam swc_row_t ROWS [10] = '{
        '{1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1}, '{1'b1, 1'b0, 1'b0, 1'b0, 2'h1, 1'b1},
        '{1'b1, 1'b0, 1'b0, 1'b0, 2'h2, 1'b1}, '{1'b1, 1'b0, 1'b1, 1'b1, 2'h3, 1'b0},
        '{1'b0, 1'b1, 1'b0, 1'b1, 2'h0, 1'b0}, '{1'b0, 1'b1, 1'b1, 1'b0, 2'h0, 1'b0},
        '{1'b0, 1'b1, 1'b1, 1'b1, 2'h2, 1'b0}, '{1'b0, 1'b1, 1'b1, 1'b1, 2'h3, 1'b0},
        '{1'b0, 1'b1, 1'b1, 1'b1, 2'h0, 1'b1}, '{1'b0, 1'b1, 1'b1, 1'b1, 2'h1, 1'b1}};

    logic        sys_clk = 1'b0, rst_n = 1'b0;
    logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, regRdData, d;
    logic        regWr = 1'b0, regRd = 1'b0, nmiPin = 1'b0;
    logic [3:0]  wakePinReq = 4'h0, wakePinEn = 4'h0;
    logic        maskReq = 1'b0, maskEn = 1'b0, masterIntEnable = 1'b0;
    logic [1:0]  interruptLevel = 2'h0;
    logic        cpuOnFastClock = 1'b0, sPrev = 1'b0, fPrev = 1'b0;
    logic        slowOscTick, fastOscTick, slowOscReady, fastOscReady;
    logic        slowOscEnable, fastOscEnable, periphSlowClkEn;
    logic        periphFastClkEn, cpuRun, haltActive, stopActive, vectorReq;
    logic [39:0] periphHold;
    int          miscompares = 0, checks_done = 0, n, v, sCnt = 0, fCnt = 0;

    swc_standby_wakeup_control #(.SETTLE_COUNT(SETTLE))
        swc_standby_wakeup_control_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .nmiPin(nmiPin), .wakePinReq(wakePinReq),
        .wakePinEn(wakePinEn), .maskReq(maskReq), .maskEn(maskEn),
        .masterIntEnable(masterIntEnable), .interruptLevel(interruptLevel),
        .cpuOnFastClock(cpuOnFastClock), .slowOscTick(slowOscTick),
        .fastOscTick(fastOscTick), .slowOscReady(slowOscReady),
        .fastOscReady(fastOscReady), .slowOscEnable(slowOscEnable),
        .fastOscEnable(fastOscEnable), .periphSlowClkEn(periphSlowClkEn),
        .periphFastClkEn(periphFastClkEn), .cpuRun(cpuRun),
        .haltActive(haltActive), .stopActive(stopActive),
        .vectorReq(vectorReq), .periphHold(periphHold));
    swc_osc_model #(.START(20), .DIV(2)) swc_osc_model_i (.sys_clk(sys_clk),
        .oscEnable(slowOscEnable), .oscTick(slowOscTick),
        .oscReady(slowOscReady));
    swc_osc_model #(.START(6), .DIV(1)) swc_osc_model_fast_i (
        .sys_clk(sys_clk), .oscEnable(fastOscEnable), .oscTick(fastOscTick),
        .oscReady(fastOscReady));

    // ********************
    // Clock, pulse counters
    // ********************
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        sPrev <= slowOscTick;
        fPrev <= fastOscTick;
        sCnt <= !slowOscReady ? 0 : sCnt + int'(slowOscTick && !sPrev);
        fCnt <= !fastOscReady ? 0 : fCnt + int'(fastOscTick && !fPrev);
    end

    // ********************
    // Tasks
    // ********************
    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s exp %b got %b", nm, e, g);
        end
    endtask
    task automatic chk_byte(input string nm, input logic [7:0] e,
                            input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk_hold(input logic [39:0] e);
        checks_done++;
        if (periphHold !== e) begin
            miscompares++;
            $display("mismatch hold exp %h got %h", e, periphHold);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic give_up();
        miscompares++;
        $display("mismatch wait exp done got timeout");
        tally_and_finish();
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= w;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask
    task automatic run_row(input swc_row_t r);
        @(posedge sys_clk);
        interruptLevel <= r.lvl;
        masterIntEnable <= r.master_int_enable;
        maskEn <= r.men;
        wr(ADDR_STANDBY_CTRL, 8'h05);
        chk_bit("halt", 1'b1, haltActive);
        @(posedge sys_clk);
        nmiPin <= r.nmi;
        maskReq <= r.mreq;
        v = 0;
        repeat (20) begin
            tick(1);
            if (vectorReq === 1'b1) v++;
        end
        chk_byte("vector", {7'h00, r.vec}, 8'(v));
        chk_bit("run", 1'b1, cpuRun & !haltActive);
        @(posedge sys_clk);
        nmiPin <= 1'b0;
        maskReq <= 1'b0;
        rd(ADDR_STANDBY_CTRL);
        chk_byte("ctrl", 8'h04, d);
        tick(3);
    endtask
    task automatic run_stop(input logic fast, input logic [7:0] ctl);
        @(posedge sys_clk);
        cpuOnFastClock <= fast;
        maskEn <= 1'b0;
        masterIntEnable <= fast;
        wr(ADDR_STANDBY_CTRL, ctl & 8'hfd);  // Fast osc state before stop
        wr(ADDR_STOP_GATE, 8'h53);
        wr(ADDR_STOP_GATE, 8'ha7);
        rd(ADDR_STOP_GATE);
        chk_byte("armed", 8'h01, d & 8'h01);
        wr(ADDR_STANDBY_CTRL, ctl);
        chk_bit("pend", 1'b0, stopActive);
        tick(1);
        chk_bit("stop", 1'b1, stopActive);
        chk_bit("oscs", 1'b0, slowOscEnable | fastOscEnable);
        tick(2);  // Idle slots after the stop write
        rd(ADDR_STOP_GATE);
        chk_byte("disarm", 8'h00, d & 8'h01);
        @(posedge sys_clk);
        maskReq <= 1'b1;
        wakePinReq <= 4'h1;
        tick(8);
        chk_bit("noWake", 1'b0, slowOscEnable);
        @(posedge sys_clk);
        maskReq <= 1'b0;
        wakePinEn <= 4'h1;
        for (n = 0; n < 10 && slowOscEnable !== 1'b1; n++) tick(1);
        if (n == 10) give_up();
        chk_bit("fastEn", fast | ctl[FAST_CTL_BIT], fastOscEnable);
        for (n = 0; n < 400 && cpuRun !== 1'b1; n++) tick(1);
        if (n == 400) give_up();
        chk_bit("settle", 1'b1, (fast ? fCnt : sCnt) >= SETTLE);
        chk_bit("pSlow", !fast, periphSlowClkEn);
        chk_bit("pFast", fast | ctl[FAST_CTL_BIT], periphFastClkEn);
        v = 0;
        repeat (4) begin
            tick(1);
            if (vectorReq === 1'b1) v++;
        end
        chk_byte("stopVec", {7'h00, fast}, 8'(v));
        for (n = 0; n < 400 && periphSlowClkEn !== 1'b1; n++) tick(1);
        if (n == 400) give_up();
        chk_bit("slowSettle", 1'b1, sCnt >= SETTLE);
        @(posedge sys_clk);
        wakePinReq <= 4'h0;
        wakePinEn <= 4'h0;
        rd(ADDR_STANDBY_CTRL);
        chk_byte("ctrl", ctl & 8'hfd, d);
    endtask

    // ********************
    // Main sequence
    // ********************
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(3);
        chk_bit("up", 1'b1, slowOscEnable & fastOscEnable & cpuRun);
        chk_bit("pclk", 1'b1, periphSlowClkEn & periphFastClkEn);
        chk_hold(40'h00_0000_0000);
        rd(ADDR_STANDBY_CTRL);
        chk_byte("ctrl", 8'h04, d);
        wr(8'h20, 8'hff);
        rd(8'h20);
        chk_byte("unmapped", RD_UNMAPPED, d);
        wr(ADDR_STANDBY_CTRL, 8'h06);
        tick(3);
        chk_bit("unarmed", 1'b0, stopActive);
        $display("test reset and bus done");
        foreach (ROWS[i]) run_row(ROWS[i]);
        $display("test halt table done");
        run_stop(1'b0, 8'h06);
        run_stop(1'b0, 8'h02);
        run_stop(1'b1, 8'h06);
        $display("test stop done");
        for (n = 0; n < GATE_COUNT; n++) wr(ADDR_GATE_BASE + 8'(n), 8'hff);
        for (n = 0; n < GATE_COUNT; n++) begin
            rd(ADDR_GATE_BASE + 8'(n));
            chk_byte("gate", 8'hff, d);
        end
        chk_hold(40'hef_ffff_ffff);
        @(posedge sys_clk);
        maskEn <= 1'b1;
        masterIntEnable <= 1'b1;
        interruptLevel <= 2'h0;
        wr(ADDR_STANDBY_CTRL, 8'h05);
        tick(12);
        chk_bit("stay", 1'b1, haltActive);
        chk_hold(40'hff_ffff_ffff);
        @(posedge sys_clk);
        interruptLevel <= 2'h3;
        nmiPin <= 1'b1;
        tick(8);
        chk_bit("woke", 1'b0, haltActive);
        chk_hold(40'hef_ffff_ffff);
        @(posedge sys_clk);
        nmiPin <= 1'b0;
        rst_n <= 1'b0;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk_hold(40'h00_0000_0000);
        rd(ADDR_GATE_BASE);
        chk_byte("gateRst", 8'h00, d);
        $display("test gates done");
        tally_and_finish();
    end
endmodule
